//--- hw/eim_mask_logic.sv
/*
 * eim_mask_logic: interrupt mask words for the receive side of the e1
 * framer, the shared interrupt request and its acknowledge/suspend bits.
 * assumes: event inputs are one-cycle pulses from detectors on i_clk_sys;
 * the register port request is already on i_clk_sys and strobes last one
 * cycle; the pin buffer resolves irq from o_irq_n and o_irq_oe_n.
 */
// Functional notes
// - mask word 0 bit 7 lets frame sync loss changes raise interrupt
// - mask word 0 bit 6 lets multiframe sync changes raise interrupt
// - mask word 0 bit 5 lets crc-4 multiframe sync changes interrupt
// - mask word 0 bit 4 lets received alarm indication changes interrupt
// - mask word 0 bit 3 lets loss of signal changes interrupt
// - mask word 0 bit 2 lets two errored alignment words interrupt
// - mask word 0 bit 1 lets remote multiframe alarm changes interrupt
// - mask word 0 bit 0 lets controlled frame slips interrupt
// - mask word 1 bit 7 lets alignment word errors interrupt
// - mask word 1 bit 6 lets local crc-4 errors interrupt
// - mask word 1 bit 5 lets remote crc error reports interrupt
// - mask word 1 bit 4 lets slot 16 alarm indication interrupt
// - mask word 1 bit 3 lets line code violations interrupt
// - mask word 1 bit 2 lets single test pattern errors interrupt
// - mask word 1 bit 1 lets aux pattern status rising interrupt
// - mask word 1 bit 0 lets remote alarm indication interrupt
// - mask word 2 bit 7 alignment error counter overflow; bit 5 unused
// - mask word 2 bits 6 and 4 crc and e-bit counter overflows
// - mask word 2 bit 3 line code counter wrap interrupts
// - mask word 2 bit 2 test pattern counter wrap interrupts
// - mask word 2 bit 1 test multiframe counter overflow interrupts
// - mask word 2 bit 0 spare bit or nibble change, per select
// - an acknowledge bit toggle clears pending unless an unmasked event lands with it, request returns high
// - suspend floats request output and ignores all events

`timescale 1ns/1ps
`default_nettype none

module eim_mask_logic (
	// clock and reset
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_srst,
	// register port
	input  wire eim_pkg::eim_reg_req_t    i_reg_req,
	output var  logic [eim_pkg::DATA_W-1:0] o_reg_rdata,
	// event pulses from the detectors
	input  wire eim_pkg::eim_events_t     i_events,
	input  wire logic                     i_sa_nibble_change,
	input  wire logic                     i_spare_bit_or_nibble_select,
	// interrupt request pin, active low, three-state
	output var  logic                     o_irq_n,
	output var  logic                     o_irq_oe_n
);

	eim_pkg::eim_state_t st_q;
	eim_pkg::eim_state_t st_d;

	logic [eim_pkg::DATA_W-1:0] ev_word [eim_pkg::NUM_MASK_WORDS];
	logic [eim_pkg::NUM_MASK_WORDS-1:0] word_hit;
	logic [eim_pkg::NUM_MASK_WORDS-1:0] mask_wr;
	logic                               ctrl_wr;
	logic                               ack_toggle;
	logic                               any_hit;

	// address decode shared by the write and read paths
	function automatic logic reg_sel(
		input eim_pkg::eim_reg_req_t req,
		input logic [eim_pkg::ADDR_W-1:0] off
	);
		reg_sel = req.cs && (req.page == eim_pkg::MASK_PAGE)
			&& (req.addr == off);
	endfunction : reg_sel

	function automatic logic [eim_pkg::ADDR_W-1:0] mask_offset(
		input int unsigned idx
	);
		case (idx)
			0: mask_offset = eim_pkg::SYNC_ALARM_EVENT_MASK_OFFSET;
			1: mask_offset = eim_pkg::ERROR_EVENT_MASK_OFFSET;
			default: mask_offset = eim_pkg::COUNTER_OVERFLOW_MASK_OFFSET;
		endcase
	endfunction : mask_offset

	// spare bit select
	// the select picks which change detector feeds the spare bit position
	always_comb begin
		ev_word[0] = i_events.sync_alarm;
		ev_word[1] = i_events.error;
		ev_word[2] = i_events.counter_wrap & eim_pkg::W2_USED;
		ev_word[2][eim_pkg::SA_CHANGE_BIT] = i_spare_bit_or_nibble_select
			? i_events.counter_wrap[eim_pkg::SA_CHANGE_BIT]
			: i_sa_nibble_change;
	end

	// per-word gating
	// masks gate only the request; detectors and counters never see them
	genvar gw;
	generate
		for (gw = 0; gw < eim_pkg::NUM_MASK_WORDS; gw++) begin : g_word
			assign word_hit[gw] = |(ev_word[gw] & st_q.mask[gw]);
			assign mask_wr[gw] = i_reg_req.wr
				&& reg_sel(i_reg_req, mask_offset(gw));
		end
	endgenerate

	assign ctrl_wr = i_reg_req.wr && reg_sel(i_reg_req, eim_pkg::CTRL_OFFSET);
	assign any_hit = |word_hit;

	// acknowledge on either edge
	// a write that leaves the bit unchanged is not an acknowledge
	assign ack_toggle = ctrl_wr
		&& (i_reg_req.wdata[eim_pkg::ACK_BIT] != st_q.ack);

	always_comb begin
		st_d = st_q;
		for (int w = 0; w < int'(eim_pkg::NUM_MASK_WORDS); w++) begin
			if (mask_wr[w]) begin
				st_d.mask[w] = i_reg_req.wdata;
			end
		end
		st_d.mask[2][eim_pkg::UNUSED_W2_BIT] = 1'b0;
		if (ctrl_wr) begin
			st_d.suspend = i_reg_req.wdata[eim_pkg::SUSPEND_BIT];
			st_d.ack = i_reg_req.wdata[eim_pkg::ACK_BIT];
		end
		// set wins over acknowledge
		// an event landing with the acknowledge is kept, never lost
		if (any_hit && !st_q.suspend) begin
			st_d.pending = 1'b1;
		end else if (ack_toggle) begin
			st_d.pending = 1'b0;
		end
		st_d.irq_n = !st_d.pending;
		st_d.irq_oe_n = st_d.suspend;
		st_d.rdata = eim_pkg::DATA_ZERO;
		if (i_reg_req.rd) begin
			for (int w = 0; w < int'(eim_pkg::NUM_MASK_WORDS); w++) begin
				if (reg_sel(i_reg_req, mask_offset(w))) begin
					st_d.rdata = st_q.mask[w];
				end
			end
			if (reg_sel(i_reg_req, eim_pkg::CTRL_OFFSET)) begin
				st_d.rdata[eim_pkg::SUSPEND_BIT] = st_q.suspend;
				st_d.rdata[eim_pkg::ACK_BIT] = st_q.ack;
			end
			if (reg_sel(i_reg_req, eim_pkg::IRQ_STATUS_OFFSET)) begin
				st_d.rdata[eim_pkg::STAT_PENDING_BIT] = st_q.pending;
				st_d.rdata[eim_pkg::STAT_SUSPEND_BIT] = st_q.suspend;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			for (int w = 0; w < int'(eim_pkg::NUM_MASK_WORDS); w++) begin
				st_q.mask[w] <= eim_pkg::MASK_RESET;
			end
			st_q.suspend <= 1'b0;
			st_q.ack <= 1'b0;
			st_q.pending <= 1'b0;
			st_q.irq_n <= 1'b1;
			st_q.irq_oe_n <= 1'b0;
			st_q.rdata <= eim_pkg::DATA_ZERO;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_reg_rdata = st_q.rdata;
	assign o_irq_n = st_q.irq_n;
	assign o_irq_oe_n = st_q.irq_oe_n;

	// checks: a masked-in pulse reaches the pin one edge later
	sequence s_live_event(logic ev, logic msk);
		ev && msk && !st_q.suspend;
	endsequence

	sequence s_irq_low;
		!o_irq_n;
	endsequence

	property p_event_to_irq(logic ev, logic msk);
		@(posedge i_clk_sys) disable iff (i_srst)
		s_live_event(ev, msk) |=> s_irq_low;
	endproperty

	AST_FRAME_SYNC: assert property (
		p_event_to_irq(i_events.sync_alarm[7], st_q.mask[0][7]))
		else $error("frame sync change did not raise request");

	AST_MF_SYNC: assert property (
		p_event_to_irq(i_events.sync_alarm[6], st_q.mask[0][6]))
		else $error("multiframe sync change did not raise request");

	AST_CRC_MF_SYNC: assert property (
		p_event_to_irq(i_events.sync_alarm[5], st_q.mask[0][5]))
		else $error("crc multiframe sync change did not raise request");

	AST_SLIP: assert property (
		p_event_to_irq(i_events.sync_alarm[0], st_q.mask[0][0]))
		else $error("frame slip did not raise request");

	AST_FRAME_ERR: assert property (
		p_event_to_irq(i_events.error[7], st_q.mask[1][7]))
		else $error("alignment error did not raise request");

	AST_REMOTE_ALARM: assert property (
		p_event_to_irq(i_events.error[0], st_q.mask[1][0]))
		else $error("remote alarm did not raise request");

	AST_FRAME_WRAP: assert property (
		p_event_to_irq(i_events.counter_wrap[7], st_q.mask[2][7]))
		else $error("alignment counter wrap did not raise request");

	AST_AIS_CHANGE: assert property (
		p_event_to_irq(i_events.sync_alarm[4], st_q.mask[0][4]))
		else $error("alarm indication change did not raise request");
	AST_LOS_CHANGE: assert property (
		p_event_to_irq(i_events.sync_alarm[3], st_q.mask[0][3]))
		else $error("signal loss change did not raise request");
	AST_TWO_FRAME_ERR: assert property (
		p_event_to_irq(i_events.sync_alarm[2], st_q.mask[0][2]))
		else $error("two errored alignment words did not raise request");
	AST_REMOTE_MF_ALARM: assert property (
		p_event_to_irq(i_events.sync_alarm[1], st_q.mask[0][1]))
		else $error("remote multiframe alarm did not raise request");
	AST_LOCAL_CRC: assert property (
		p_event_to_irq(i_events.error[6], st_q.mask[1][6]))
		else $error("local crc error did not raise request");
	AST_REMOTE_CRC: assert property (
		p_event_to_irq(i_events.error[5], st_q.mask[1][5]))
		else $error("remote crc report did not raise request");
	AST_SLOT16_ALARM: assert property (
		p_event_to_irq(i_events.error[4], st_q.mask[1][4]))
		else $error("slot 16 alarm did not raise request");
	AST_LINE_CODE: assert property (
		p_event_to_irq(i_events.error[3], st_q.mask[1][3]))
		else $error("line code violation did not raise request");
	AST_TEST_PATTERN: assert property (
		p_event_to_irq(i_events.error[2], st_q.mask[1][2]))
		else $error("test pattern error did not raise request");
	AST_AUX_PATTERN: assert property (
		p_event_to_irq(i_events.error[1], st_q.mask[1][1]))
		else $error("aux pattern status did not raise request");
	AST_CRC_WRAP: assert property (
		p_event_to_irq(i_events.counter_wrap[6], st_q.mask[2][6]))
		else $error("crc counter wrap did not raise request");
	AST_EBIT_WRAP: assert property (
		p_event_to_irq(i_events.counter_wrap[4], st_q.mask[2][4]))
		else $error("remote crc counter wrap did not raise request");
	AST_LINE_CODE_WRAP: assert property (
		p_event_to_irq(i_events.counter_wrap[3], st_q.mask[2][3]))
		else $error("line code counter wrap did not raise request");
	AST_PATTERN_WRAP: assert property (
		p_event_to_irq(i_events.counter_wrap[2], st_q.mask[2][2]))
		else $error("test pattern counter wrap did not raise request");
	AST_MF_WRAP: assert property (
		p_event_to_irq(i_events.counter_wrap[1], st_q.mask[2][1]))
		else $error("test multiframe counter wrap did not raise request");

	AST_UNUSED_BIT: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		!st_q.mask[2][eim_pkg::UNUSED_W2_BIT])
		else $error("unused mask bit became set");

	AST_SA_NIBBLE: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(!i_spare_bit_or_nibble_select && i_sa_nibble_change
			&& st_q.mask[2][eim_pkg::SA_CHANGE_BIT] && !st_q.suspend)
		|=> !o_irq_n)
		else $error("sa nibble change did not raise request");

	AST_SA_SELECT: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(!i_spare_bit_or_nibble_select && !i_sa_nibble_change
			&& ($countones(ev_word[0] & st_q.mask[0]) == 0)
			&& ($countones(ev_word[1] & st_q.mask[1]) == 0)
			&& ($countones(i_events.counter_wrap & st_q.mask[2]
				& 8'hde) == 0)
			&& !st_q.pending && !ack_toggle)
		|=> o_irq_n)
		else $error("spare bit change leaked through nibble select");

	sequence s_ack_write;
		ack_toggle && !(any_hit && !st_q.suspend);
	endsequence

	AST_ACK_CLEARS: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		s_ack_write |=> (o_irq_n && !st_q.pending))
		else $error("acknowledge did not release request");

	AST_SET_WINS: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(ack_toggle && any_hit && !st_q.suspend) |=> !o_irq_n)
		else $error("event lost against acknowledge");

	AST_SUSPEND_FLOAT: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(ctrl_wr && i_reg_req.wdata[eim_pkg::SUSPEND_BIT])
		|=> o_irq_oe_n ##1 (o_irq_oe_n || $past(ctrl_wr)))
		else $error("suspend did not float request pin");

	AST_SUSPEND_IGNORE: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(st_q.suspend && !st_q.pending) |=> !st_q.pending)
		else $error("event accepted while suspended");

	AST_NO_SPURIOUS: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		($rose(st_q.pending)) |-> $past(any_hit && !st_q.suspend))
		else $error("request raised with no unmasked event");

	AST_HOLD: assert property (
		@(posedge i_clk_sys) disable iff (i_srst)
		(!o_irq_n && !ack_toggle) |=> !o_irq_n)
		else $error("request dropped without acknowledge");

endmodule : eim_mask_logic

`default_nettype wire

//--- hw/eim_pkg.sv
/*
 * eim_pkg: constants and carrier types for the receive-side event mask
 * block of the e1 framer.
 * assumes: the register port request is brought onto the system clock
 * before it reaches this block, which decodes page and address itself.
 */
package eim_pkg;

	// register port geometry
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned PAGE_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_MASK_WORDS = 3;

	// page and offsets of the registers held here
	localparam logic [PAGE_W-1:0] MASK_PAGE = 3'h1;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 5'h19;
	localparam logic [ADDR_W-1:0] SYNC_ALARM_EVENT_MASK_OFFSET = 5'h1b;
	localparam logic [ADDR_W-1:0] ERROR_EVENT_MASK_OFFSET = 5'h1c;
	localparam logic [ADDR_W-1:0] COUNTER_OVERFLOW_MASK_OFFSET = 5'h1d;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 5'h0f;

	// control word fields
	localparam int unsigned SUSPEND_BIT = 6;
	localparam int unsigned ACK_BIT = 5;

	// status word fields
	localparam int unsigned STAT_PENDING_BIT = 0;
	localparam int unsigned STAT_SUSPEND_BIT = 1;

	// fixed-position bits in the mask words
	localparam int unsigned SA_CHANGE_BIT = 0;
	localparam int unsigned UNUSED_W2_BIT = 5;

	// reset values: everything masked, interrupts running
	localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] W2_USED = 8'hdf;

	// one event word per mask word, bit for bit
	typedef struct packed {
		logic [DATA_W-1:0] counter_wrap;
		logic [DATA_W-1:0] error;
		logic [DATA_W-1:0] sync_alarm;
	} eim_events_t;

	// host register port request
	typedef struct packed {
		logic              cs;
		logic              wr;
		logic              rd;
		logic [PAGE_W-1:0] page;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} eim_reg_req_t;

	// whole state of the block
	typedef struct packed {
		logic [NUM_MASK_WORDS-1:0][DATA_W-1:0] mask;
		logic                                  suspend;
		logic                                  ack;
		logic                                  pending;
		logic                                  irq_n;
		logic                                  irq_oe_n;
		logic [DATA_W-1:0]                     rdata;
	} eim_state_t;

endpackage : eim_pkg

//--- sim/eim_host_model.sv
/*
 * eim_host_model: host processor on the register port of the mask block.
 * assumes: one clock shared with the block, one access at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module eim_host_model (
	// clock
	input  wire logic                       i_clk_sys,
	// register port
	output var  eim_pkg::eim_reg_req_t      o_req,
	input  wire logic [eim_pkg::DATA_W-1:0] i_rdata
);
	initial o_req = '0;

	// request held over one taking edge; idle address and data flip so stale data
	// can never pass for a live request
	task automatic access(input logic wr, input logic [2:0] page,
		input logic [4:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		@(posedge i_clk_sys);
		#1;
		o_req.cs = 1'b1;
		o_req.wr = wr;
		o_req.rd = !wr;
		o_req.page = page;
		o_req.addr = addr;
		o_req.wdata = wdata;
		@(posedge i_clk_sys);
		#1;
		o_req.cs = 1'b0;
		o_req.wr = 1'b0;
		o_req.rd = 1'b0;
		o_req.addr = ~addr;
		o_req.wdata = ~wdata;
		rdata = i_rdata;
	endtask : access
endmodule : eim_host_model

`default_nettype wire

//--- sim/tb.sv
/*
 * tb: self-checking bench for the event mask block.
 * assumes: the host model drives the register port, events come from here.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                  i_clk_sys = 1'b0;
	logic                  i_srst = 1'b1;
	eim_pkg::eim_reg_req_t req;
	logic [7:0]            rdata;
	eim_pkg::eim_events_t  ev = '0;
	logic                  nib = 1'b0;
	logic                  sel = 1'b1;
	logic                  irq_n;
	logic                  irq_oe_n;
	logic                  ack_q = 1'b0;
	logic                  susp = 1'b0;
	int                    mismatches = 0;
	int                    total_checks = 0;

	always #50 i_clk_sys = ~i_clk_sys;

	eim_host_model host (.i_clk_sys(i_clk_sys), .o_req(req), .i_rdata(rdata));

	eim_mask_logic dut (
		.i_clk_sys(i_clk_sys), .i_srst(i_srst),
		.i_reg_req(req), .o_reg_rdata(rdata),
		.i_events(ev), .i_sa_nibble_change(nib),
		.i_spare_bit_or_nibble_select(sel),
		.o_irq_n(irq_n), .o_irq_oe_n(irq_oe_n));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] unused;
		host.access(1'b1, eim_pkg::MASK_PAGE, a, d, unused);
	endtask : wr

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.access(1'b0, eim_pkg::MASK_PAGE, a, 8'h00, d);
		chk(d, exp);
		// read data stands one cycle, then falls back to zero
		@(posedge i_clk_sys);
		#1;
		chk(rdata, 8'h00);
	endtask : rd_chk

	// control write: toggles acknowledge when asked, keeps suspend
	task automatic ctrl(input logic toggle);
		ack_q = ack_q ^ toggle;
		wr(eim_pkg::CTRL_OFFSET, {1'b0, susp, ack_q, 5'h00});
	endtask : ctrl

	// one-cycle pulse, then the request level seen after the taking edge
	task automatic pulse(input logic [23:0] e, input logic n, input logic exp);
		@(posedge i_clk_sys);
		#1;
		ev = e;
		nib = n;
		@(posedge i_clk_sys);
		#1;
		ev = '0;
		nib = 1'b0;
		chk({7'h00, irq_n}, {7'h00, exp});
	endtask : pulse

	task automatic t_reset;
		chk(rdata, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
		chk({7'h00, irq_oe_n}, 8'h00);
		for (int w = 0; w < 3; w++) begin
			rd_chk(5'h1b + 5'(w), 8'h00);
		end
	endtask : t_reset

	task automatic t_regs;
		logic [7:0] d;
		// another page at the same offset must not reach the mask
		host.access(1'b1, 3'h2, 5'h1b, 8'hff, d);
		rd_chk(5'h1b, 8'h00);
		for (int w = 0; w < 3; w++) begin
			wr(5'h1b + 5'(w), 8'hff);
			rd_chk(5'h1b + 5'(w), (w == 2) ? 8'hdf : 8'hff);
			wr(5'h1b + 5'(w), 8'h00);
		end
		// unmapped place: write dropped, read gives zero
		wr(5'h1e, 8'haa);
		rd_chk(5'h1e, 8'h00);
	endtask : t_regs

	// each mask bit gates its event
	task automatic t_each;
		logic [23:0] one;
		for (int i = 0; i < 24; i++) begin
			one = 24'h000001 << i;
			wr(5'h1b + 5'(i / 8), 8'h01 << (i % 8));
			pulse(~one, 1'b1, 1'b1);
			pulse(one, 1'b0, (i == 21));
			ctrl(1'b0);
			chk({7'h00, irq_n}, {7'h00, (i == 21)});
			ctrl(1'b1);
			chk({7'h00, irq_n}, 8'h01);
			wr(5'h1b + 5'(i / 8), 8'h00);
		end
	endtask : t_each

	// nibble source when select is low
	task automatic t_nibble;
		sel = 1'b0;
		wr(eim_pkg::COUNTER_OVERFLOW_MASK_OFFSET, 8'h01);
		pulse(24'h010000, 1'b0, 1'b1);
		pulse(24'h000000, 1'b1, 1'b0);
		ctrl(1'b1);
		sel = 1'b1;
		wr(eim_pkg::COUNTER_OVERFLOW_MASK_OFFSET, 8'h00);
	endtask : t_nibble

	// suspend floats the pin and drops events
	task automatic t_suspend;
		wr(eim_pkg::SYNC_ALARM_EVENT_MASK_OFFSET, 8'h01);
		pulse(24'h000001, 1'b0, 1'b0);
		susp = 1'b1;
		ctrl(1'b0);
		chk({7'h00, irq_oe_n}, 8'h01);
		rd_chk(eim_pkg::IRQ_STATUS_OFFSET, 8'h03);
		ctrl(1'b1);
		pulse(24'h000001, 1'b0, 1'b1);
		rd_chk(eim_pkg::CTRL_OFFSET, {1'b0, susp, ack_q, 5'h00});
		susp = 1'b0;
		ctrl(1'b0);
		chk({7'h00, irq_oe_n}, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
		wr(eim_pkg::SYNC_ALARM_EVENT_MASK_OFFSET, 8'h00);
	endtask : t_suspend

	// event and acknowledge on one edge: the event wins
	task automatic t_collide;
		wr(eim_pkg::SYNC_ALARM_EVENT_MASK_OFFSET, 8'h01);
		fork
			ctrl(1'b1);
			pulse(24'h000001, 1'b0, 1'b0);
		join
		ctrl(1'b1);
		chk({7'h00, irq_n}, 8'h01);
		wr(eim_pkg::SYNC_ALARM_EVENT_MASK_OFFSET, 8'h00);
	endtask : t_collide

	// reset in mid-run drops masks, suspend and a pending request
	task automatic t_midreset;
		wr(eim_pkg::ERROR_EVENT_MASK_OFFSET, 8'h80);
		pulse(24'h008000, 1'b0, 1'b0);
		susp = 1'b1;
		ctrl(1'b0);
		chk({7'h00, irq_oe_n}, 8'h01);
		@(posedge i_clk_sys);
		#1;
		i_srst = 1'b1;
		repeat (2) @(posedge i_clk_sys);
		#1;
		i_srst = 1'b0;
		susp = 1'b0;
		ack_q = 1'b0;
		t_reset;
		rd_chk(eim_pkg::CTRL_OFFSET, 8'h00);
		rd_chk(eim_pkg::IRQ_STATUS_OFFSET, 8'h00);
	endtask : t_midreset

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (10) @(posedge i_clk_sys);
		#1;
		i_srst = 1'b0;
		t_reset;
		t_regs;
		t_each;
		t_nibble;
		t_suspend;
		t_collide;
		t_midreset;
		end_of_test;
	end

	// whole run is well under a thousand cycles
	initial begin
		#1_000_000;
		mismatches++;
		end_of_test;
	end
endmodule : tb

`default_nettype wire
